// ==== rtl/led_spi_pkg.sv ====
package led_spi_pkg;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 8;
  localparam int UP_NIB_HI = 15;
  localparam int UP_NIB_LO = 12;
  localparam int LOW_NIB_HI = 11;
  localparam int LOW_NIB_LO = 8;
  localparam int DATA_HI = 7;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [3:0] ADDR_NOP = 4'h0;
  localparam logic [3:0] ADDR_DIM_ONE = 4'h1;
  localparam logic [3:0] ADDR_DIM_TWO = 4'h2;
  localparam logic [3:0] ADDR_CUR_ONE = 4'h3;
  localparam logic [3:0] ADDR_CUR_TWO = 4'h4;
  localparam logic [3:0] ADDR_SHORT_ONE = 4'h5;
  localparam logic [3:0] ADDR_SHORT_TWO = 4'h6;
  localparam logic [3:0] ADDR_BOOST = 4'h7;
  localparam logic [3:0] ADDR_OFFTIME = 4'h8;
  localparam logic [3:0] ADDR_FUSE = 4'h9;
  localparam logic [3:0] ADDR_STATUS_FIRST = 4'hc;
  localparam logic [3:0] ADDR_STATUS_TWO = 4'hd;
  localparam int CTRL_LAST = 9;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int LOCK_BIT = 7;
  localparam int BOOST_OFF_BIT = 7;
  localparam int DERATE_OFF_BIT = 3;
  localparam int FUSE_START_BIT = 7;
  localparam int FUSE_RSVD_BIT = 4;
  localparam int SPI_ERR_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] RESP_RESET = 16'h0000;

endpackage : led_spi_pkg

// ==== rtl/link_if.sv ====
`timescale 1ns/1ps
interface link_if;
  logic [15:0] shiftWord;
  logic [7:0] riseCount;
  logic [7:0] fallCount;
  logic [7:0] frameStart;
  logic [15:0] respWord;

  modport link (
    output shiftWord,
    output riseCount,
    output fallCount,
    input frameStart,
    input respWord
  );

  modport core (
    input shiftWord,
    input riseCount,
    input fallCount,
    output frameStart,
    output respWord
  );
endinterface : link_if

// ==== rtl/sync_three.sv ====
`timescale 1ns/1ps
module sync_three #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins in, settled value out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] settled
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit moves only once the last two stages agree
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        settled[i] <= 1'b0;
      end else if (stage2[i] == stage3[i]) begin
        settled[i] <= stage3[i];
      end
    end
  end

endmodule : sync_three

// ==== rtl/spi_link_shift.sv ====
`timescale 1ns/1ps
module spi_link_shift (
  // Link clock and reset
  input wire logic sclk,
  input wire logic rst,
  // Serial data
  input wire logic mosi,
  output logic misoBit,
  // Words shared with the core
  link_if.link lnk
);

  logic [3:0] txIndex;

  // Sample on the rising edge; counters run free so no edge is
  // needed at frame boundaries
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      lnk.shiftWord <= '0;
      lnk.riseCount <= '0;
    end else begin
      lnk.shiftWord <= {lnk.shiftWord[14:0], mosi};
      lnk.riseCount <= lnk.riseCount + 8'h01;
    end
  end

  // Falling edges advance the outgoing bit
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      lnk.fallCount <= '0;
    end else begin
      lnk.fallCount <= lnk.fallCount + 8'h01;
    end
  end

  // The first bit must stand before any link edge, so the bit is
  // picked from held words rather than shifted out of a register
  assign txIndex = 4'(lnk.fallCount - lnk.frameStart);
  assign misoBit = lnk.respWord[4'hf - txIndex];

endmodule : spi_link_shift

// ==== rtl/led_driver_spi_regmap.sv ====
`timescale 1ns/1ps
module led_driver_spi_regmap (
  // System clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial link
  input wire logic sclk,
  input wire logic chipSelectN,
  input wire logic mosi,
  output logic misoOut,
  output logic misoEn,
  // Straps and fuse state
  input wire logic testModePin,
  input wire logic fuseLockInternal,
  input wire logic fuseLockExternal,
  // Configuration to the regulators
  output logic [7:0] dimDutyOne,
  output logic [7:0] dimDutyTwo,
  output logic [6:0] currentSetOne,
  output logic [6:0] currentSetTwo,
  output logic [7:0] shortThreshOne,
  output logic [7:0] shortThreshTwo,
  output logic boostStageOff,
  output logic [2:0] boostOscFreq,
  output logic [3:0] boostOutRange,
  output logic [3:0] offTimeRange,
  output logic supplyDeratingOff,
  output logic [2:0] dimFreqFactor,
  output logic fuseStart,
  output logic [1:0] fuseCmd,
  output logic [3:0] fuseAddr,
  // Error state
  output logic spiError
);

  // ****************************************
  // Link domain
  // ****************************************
  link_if lnk ();

  spi_link_shift u_link (
    .sclk(sclk),
    .rst(rst),
    .mosi(mosi),
    .misoBit(misoOut),
    .lnk(lnk.link)
  );

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] pinsSettled;
  logic selectN;
  logic testMode;
  logic lockInt;
  logic lockExt;

  // Chip select enters inverted, so cleared stages read as deselected
  // and no false frame end or data enable follows reset
  sync_three #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn({~chipSelectN, testModePin, fuseLockInternal, fuseLockExternal}),
    .settled(pinsSettled)
  );

  assign selectN = !pinsSettled[3];
  assign testMode = pinsSettled[2];
  assign lockInt = pinsSettled[1];
  assign lockExt = pinsSettled[0];

  // ****************************************
  // Frame end detection
  // ****************************************
  logic selectPrev;
  logic frameDone;
  logic [7:0] frameBits;
  logic badFrame;
  logic goodFrame;
  logic [15:0] cmdWord;
  logic [3:0] controlRegAddress;
  logic [3:0] statusRegAddress;
  logic [7:0] controlWriteByte;

  always_ff @(posedge clk) begin
    if (rst) begin
      selectPrev <= 1'b1;
    end else begin
      selectPrev <= selectN;
    end
  end

  // Link words are still while chip select is high and the link
  // clock idles, so they are read here only after the settled rise
  assign frameDone = selectN && !selectPrev;
  assign frameBits = lnk.riseCount - lnk.frameStart;
  assign badFrame = frameDone &&
    ((frameBits % 8'(led_spi_pkg::FRAME_BITS)) != 8'h00);
  assign goodFrame = frameDone && !badFrame && (frameBits != 8'h00);
  // The last sixteen bits in are this device's command
  assign cmdWord = lnk.shiftWord;
  assign controlRegAddress =
    cmdWord[led_spi_pkg::UP_NIB_HI:led_spi_pkg::UP_NIB_LO];
  assign statusRegAddress =
    cmdWord[led_spi_pkg::LOW_NIB_HI:led_spi_pkg::LOW_NIB_LO];
  assign controlWriteByte = cmdWord[led_spi_pkg::DATA_HI:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      lnk.frameStart <= '0;
    end else if (frameDone) begin
      lnk.frameStart <= lnk.riseCount;
    end
  end

  // Chip select enables the data pin only while the frame runs
  always_ff @(posedge clk) begin
    if (rst) begin
      misoEn <= 1'b0;
    end else begin
      misoEn <= !selectN;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [led_spi_pkg::CTRL_LAST:1][7:0] ctrlReg;
  logic [7:0] writeMask [1:led_spi_pkg::CTRL_LAST];

  genvar r;
  for (r = 1; r <= led_spi_pkg::CTRL_LAST; r++) begin : g_reg
    // Fuse lock bits and the reserved fuse bit are never stored
    assign writeMask[r] =
      (4'(r) == led_spi_pkg::ADDR_CUR_ONE ||
       4'(r) == led_spi_pkg::ADDR_CUR_TWO) ?
        ~(8'h01 << led_spi_pkg::LOCK_BIT) :
      (r == led_spi_pkg::CTRL_LAST) ?
        ~(8'h01 << led_spi_pkg::FUSE_RSVD_BIT) : 8'hff;
    always_ff @(posedge clk) begin
      if (rst) begin
        ctrlReg[r] <= led_spi_pkg::CTRL_RESET;
      end else if (goodFrame && controlRegAddress == 4'(r) &&
                   (r != led_spi_pkg::CTRL_LAST || testMode)) begin
        ctrlReg[r] <= controlWriteByte & writeMask[r];
      end
    end
  end

  // Address 0 has no storage, so a write there is dropped
  assign dimDutyOne = ctrlReg[1];
  assign dimDutyTwo = ctrlReg[2];
  assign currentSetOne = ctrlReg[3][6:0];
  assign currentSetTwo = ctrlReg[4][6:0];
  assign shortThreshOne = ctrlReg[5];
  assign shortThreshTwo = ctrlReg[6];
  assign boostStageOff = ctrlReg[7][led_spi_pkg::BOOST_OFF_BIT];
  assign boostOscFreq = ctrlReg[7][6:4];
  assign boostOutRange = ctrlReg[7][3:0];
  assign offTimeRange = ctrlReg[8][7:4];
  assign supplyDeratingOff = ctrlReg[8][led_spi_pkg::DERATE_OFF_BIT];
  assign dimFreqFactor = ctrlReg[8][2:0];
  assign fuseStart = ctrlReg[9][led_spi_pkg::FUSE_START_BIT];
  assign fuseCmd = ctrlReg[9][6:5];
  assign fuseAddr = ctrlReg[9][3:0];

  // ****************************************
  // Read decode and answer
  // ****************************************
  logic respPending;
  logic [3:0] upAddrHeld;
  logic [3:0] lowAddrHeld;
  logic [7:0] registerReadByte;
  logic [7:0] upReadByte;
  logic readsErrorReg;

  function automatic logic [7:0] readOf(
    input logic [3:0] addr,
    input logic [led_spi_pkg::CTRL_LAST:1][7:0] regs,
    input logic li,
    input logic le,
    input logic err
  );
    logic [7:0] value;
    value = 8'h00;
    case (addr)
      led_spi_pkg::ADDR_DIM_ONE, led_spi_pkg::ADDR_DIM_TWO,
      led_spi_pkg::ADDR_SHORT_ONE, led_spi_pkg::ADDR_SHORT_TWO,
      led_spi_pkg::ADDR_BOOST, led_spi_pkg::ADDR_OFFTIME,
      led_spi_pkg::ADDR_FUSE: begin
        value = regs[addr];
      end
      led_spi_pkg::ADDR_CUR_ONE: begin
        value = {li, regs[addr][6:0]};
      end
      led_spi_pkg::ADDR_CUR_TWO: begin
        value = {le, regs[addr][6:0]};
      end
      led_spi_pkg::ADDR_STATUS_TWO: begin
        value[led_spi_pkg::SPI_ERR_BIT] = err;
      end
      default: begin
        value = 8'h00;
      end
    endcase
    return value;
  endfunction : readOf

  // Addresses are held so the answer sees the value just written
  always_ff @(posedge clk) begin
    if (rst) begin
      respPending <= 1'b0;
      upAddrHeld <= led_spi_pkg::ADDR_NOP;
      lowAddrHeld <= led_spi_pkg::ADDR_NOP;
    end else begin
      respPending <= goodFrame;
      if (goodFrame) begin
        upAddrHeld <= controlRegAddress;
        lowAddrHeld <= statusRegAddress;
      end
    end
  end

  // Upper nibble reads back any register, the same as the lower nibble
  assign upReadByte = (upAddrHeld >= led_spi_pkg::ADDR_STATUS_FIRST) ?
    readOf(upAddrHeld, ctrlReg, lockInt, lockExt, spiError) :
    readOf(upAddrHeld, ctrlReg, lockInt, lockExt, 1'b0) & 8'h00 |
    readOf(upAddrHeld, ctrlReg, lockInt, lockExt, 1'b0);
  assign registerReadByte =
    readOf(lowAddrHeld, ctrlReg, lockInt, lockExt, spiError);
  assign readsErrorReg = respPending &&
    (upAddrHeld == led_spi_pkg::ADDR_STATUS_TWO ||
     lowAddrHeld == led_spi_pkg::ADDR_STATUS_TWO);

  // Held for the whole next frame; it is latched long before the
  // next chip select fall, and the first frame after reset reads 0
  always_ff @(posedge clk) begin
    if (rst) begin
      lnk.respWord <= led_spi_pkg::RESP_RESET;
    end else if (respPending) begin
      lnk.respWord <= {upReadByte, registerReadByte};
    end
  end

  // ****************************************
  // Error flag
  // ****************************************
  // A new error in the clearing cycle wins over the read clear
  always_ff @(posedge clk) begin
    if (rst) begin
      spiError <= 1'b0;
    end else if (badFrame) begin
      spiError <= 1'b1;
    end else if (readsErrorReg) begin
      spiError <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_good_frame;
    goodFrame;
  endsequence

  sequence s_answer_ready;
    respPending ##1 !respPending;
  endsequence

  property p_bad_frame_discarded;
    badFrame |=> $stable(ctrlReg) ##1 $stable(lnk.respWord);
  endproperty
  a_bad_frame_discarded: assert property (p_bad_frame_discarded)
    else $error("discarded frame changed a register");

  property p_bad_frame_flags;
    badFrame |=> spiError [*2];
  endproperty
  a_bad_frame_flags: assert property (p_bad_frame_flags)
    else $error("error flag not raised by bad frame");

  property p_answer_next_frame;
    s_good_frame |-> ##1 s_answer_ready ##0
      (lnk.respWord[7:0] == $past(registerReadByte));
  endproperty
  a_answer_next_frame: assert property (p_answer_next_frame)
    else $error("answer not loaded two cycles after frame");

  property p_answer_holds;
    !respPending |=> $stable(lnk.respWord);
  endproperty
  a_answer_holds: assert property (p_answer_holds)
    else $error("answer word moved outside a load");

  property p_duty_write;
    s_good_frame ##0 (controlRegAddress == led_spi_pkg::ADDR_DIM_ONE)
      |=> dimDutyOne == $past(controlWriteByte);
  endproperty
  a_duty_write: assert property (p_duty_write)
    else $error("duty write not stored");

  property p_nop_reads_zero;
    respPending && lowAddrHeld == led_spi_pkg::ADDR_NOP
      |=> lnk.respWord[7:0] == 8'h00;
  endproperty
  a_nop_reads_zero: assert property (p_nop_reads_zero)
    else $error("nop address read nonzero");

  property p_lock_readback;
    respPending && lowAddrHeld == led_spi_pkg::ADDR_CUR_ONE
      |=> lnk.respWord[7] == $past(lockInt);
  endproperty
  a_lock_readback: assert property (p_lock_readback)
    else $error("fuse lock not shown in bit 7");

  property p_fuse_guard;
    frameDone && !testMode |=> $stable(ctrlReg[led_spi_pkg::CTRL_LAST]);
  endproperty
  a_fuse_guard: assert property (p_fuse_guard)
    else $error("fuse control written outside test mode");

  property p_write_only_at_frame_end;
    !frameDone |=> $stable(ctrlReg);
  endproperty
  a_write_only_at_frame_end:
    assert property (p_write_only_at_frame_end)
    else $error("register changed away from frame end");

  property p_low_nibble_no_write;
    s_good_frame ##0 (controlRegAddress == led_spi_pkg::ADDR_NOP)
      |=> $stable(ctrlReg);
  endproperty
  a_low_nibble_no_write: assert property (p_low_nibble_no_write)
    else $error("write without upper nibble target");

endmodule : led_driver_spi_regmap

// ==== test/spi_master_model.sv ====
`timescale 1ns/1ps
module spi_master_model (
  // Serial link to the device
  output logic sclk,
  output logic chipSelectN,
  output logic mosi,
  input wire logic misoOut,
  input wire logic misoEn
);
  localparam realtime HALF = 16.0;
  logic lastBit;
  logic line;

  // A released line never shows a stale bit
  assign line = misoEn ? misoOut : ~lastBit;

  initial begin
    sclk = 1'b0;
    chipSelectN = 1'b1;
    mosi = 1'b0;
    lastBit = 1'b0;
  end

  // ****************************************
  // One frame, mode 0, MSB first
  // ****************************************
  task automatic xfer(input logic [31:0] tx, input int nbits,
                      output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    #3.7;
    chipSelectN = 1'b0;
    // Enable lags the pin by a few system cycles
    #(HALF * 3);
    for (i = 0; i < nbits; i++) begin
      mosi = tx[nbits-1-i];
      #(HALF);
      sclk = 1'b1;
      if (i < 16) begin
        rx = {rx[14:0], line};
      end
      lastBit = line;
      #(HALF);
      sclk = 1'b0;
    end
    #(HALF);
    chipSelectN = 1'b1;
    mosi = ~mosi;
    // Clock stays low while deselected; gap covers decode
    #250;
  endtask : xfer
endmodule : spi_master_model

// ==== test/led_driver_spi_regmap_tb.sv ====
`timescale 1ns/1ps
module led_driver_spi_regmap_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk;
  logic rst;
  logic sclk;
  logic chipSelectN;
  logic mosi;
  logic misoOut;
  logic misoEn;
  logic testModePin;
  logic fuseLockInternal;
  logic fuseLockExternal;
  logic [7:0] dimDutyOne, dimDutyTwo, shortThreshOne, shortThreshTwo;
  logic [6:0] currentSetOne, currentSetTwo;
  logic boostStageOff, supplyDeratingOff, fuseStart, spiError;
  logic [2:0] boostOscFreq, dimFreqFactor;
  logic [3:0] boostOutRange, offTimeRange, fuseAddr;
  logic [1:0] fuseCmd;
  logic [7:0] regs [16];
  logic [15:0] answer;
  logic [15:0] rx;
  logic err;
  int num_errors;
  int samples_checked;
  int cycles;
  int lens [9] = '{16, 16, 16, 16, 32, 0, 8, 15, 17};

  led_driver_spi_regmap uut (.clk(clk), .rst(rst), .sclk(sclk),
    .chipSelectN(chipSelectN), .mosi(mosi), .misoOut(misoOut),
    .misoEn(misoEn), .testModePin(testModePin),
    .fuseLockInternal(fuseLockInternal),
    .fuseLockExternal(fuseLockExternal), .dimDutyOne(dimDutyOne),
    .dimDutyTwo(dimDutyTwo), .currentSetOne(currentSetOne),
    .currentSetTwo(currentSetTwo), .shortThreshOne(shortThreshOne),
    .shortThreshTwo(shortThreshTwo), .boostStageOff(boostStageOff),
    .boostOscFreq(boostOscFreq), .boostOutRange(boostOutRange),
    .offTimeRange(offTimeRange), .supplyDeratingOff(supplyDeratingOff),
    .dimFreqFactor(dimFreqFactor), .fuseStart(fuseStart),
    .fuseCmd(fuseCmd), .fuseAddr(fuseAddr), .spiError(spiError));

  spi_master_model mst (.sclk(sclk), .chipSelectN(chipSelectN),
    .mosi(mosi), .misoOut(misoOut), .misoEn(misoEn));

  always #2.5 clk = ~clk;

  // ****************************************
  // Reference model
  // ****************************************
  function automatic logic [7:0] rd(input logic [3:0] a);
    case (a)
      4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9: rd = regs[a];
      4'h3: rd = {fuseLockInternal, regs[3][6:0]};
      4'h4: rd = {fuseLockExternal, regs[4][6:0]};
      4'hd: rd = {3'h0, err, 4'h0};
      default: rd = 8'h00;
    endcase
  endfunction : rd

  task automatic model_frame(input logic [31:0] tx, input int nbits);
    logic [3:0] wa;
    logic [3:0] ra;
    logic [7:0] d;
    wa = tx[15:12];
    ra = tx[11:8];
    d = tx[7:0];
    if (nbits % 16 != 0) begin
      err = 1'b1;
    end else if (nbits != 0) begin
      if ((wa >= 4'h1 && wa <= 4'h8) || (wa == 4'h9 && testModePin)) begin
        regs[wa] = (wa == 4'h3 || wa == 4'h4) ? {1'b0, d[6:0]} :
                   (wa == 4'h9) ? (d & 8'hef) : d;
      end
      answer = {rd(wa), rd(ra)};
      if (wa == 4'hd || ra == 4'hd) begin
        err = 1'b0;
      end
    end
  endtask : model_frame

  function automatic logic [69:0] exp_outs();
    exp_outs = {regs[1], regs[2], regs[3][6:0], regs[4][6:0], regs[5],
                regs[6], regs[7], regs[8], regs[9][7:5], regs[9][3:0], err};
  endfunction : exp_outs

  // ****************************************
  // Comparisons and closing
  // ****************************************
  task automatic report(input logic [69:0] got, input logic [69:0] exp);
    num_errors++;
    $display("wrong value at %0t: got %h expected %h", $time, got, exp);
  endtask : report

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) report(got, exp);
  endtask : chk_word

  task automatic chk_outs();
    logic [69:0] got;
    got = {dimDutyOne, dimDutyTwo, currentSetOne, currentSetTwo,
           shortThreshOne, shortThreshTwo, boostStageOff, boostOscFreq,
           boostOutRange, offTimeRange, supplyDeratingOff, dimFreqFactor,
           fuseStart, fuseCmd, fuseAddr, spiError};
    samples_checked++;
    if (got !== exp_outs()) report(got, exp_outs());
  endtask : chk_outs

  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic do_frame(input logic [31:0] tx, input int nbits);
    mst.xfer(tx, nbits, rx);
    if (nbits >= 16) chk_word(rx, answer);
    model_frame(tx, nbits);
    chk_outs();
  endtask : do_frame

  task automatic set_pins(input logic t, input logic li, input logic le);
    @(negedge clk);
    testModePin = t;
    fuseLockInternal = li;
    fuseLockExternal = le;
  endtask : set_pins

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      close_out();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    testModePin = 1'b0;
    fuseLockInternal = 1'b0;
    fuseLockExternal = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    err = 1'b0;
    answer = 16'h0000;
    foreach (regs[i]) regs[i] = 8'h00;
    void'($urandom(32'hfff1));
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int c = 0; c < 6; c++) begin
      @(negedge clk);
      chk_word({15'h0000, misoEn}, 16'h0000);
    end
    chk_outs();
    set_pins(1'b0, 1'b0, 1'b1);
    do_frame(32'h402a, 16);
    do_frame(32'h14ff, 16);
    do_frame(32'h0000, 16);
    for (int t = 0; t < 2; t++) begin
      set_pins(t[0], 1'b1, 1'b0);
      do_frame(32'h9fff, 16);
      do_frame(32'h0309, 16);
    end
    do_frame(32'h1155, 17);
    do_frame(32'h10dd, 16);
    do_frame(32'h0055, 8);
    do_frame(32'hd0aa, 16);
    do_frame(32'h00002c55, 32);
    do_frame(32'h0000, 0);
    do_frame(32'h0000, 16);
    for (int n = 0; n < 60; n++) begin
      set_pins($urandom, $urandom, $urandom);
      do_frame($urandom, lens[$urandom % 9]);
    end
    close_out();
  end
endmodule : led_driver_spi_regmap_tb
